// >>> design/port_pin_regs.vh
// Register map, field positions, reset values and mode codes of the
// port pin function select block. Definitions only; include by name.
//
// Function
// - Port A pin 5 mode bit: 0 general I/O, 1 upper write/byte strobe.
// - Bit 9 of port A low function reads 1; software writes 1.
// - Port A pin 4 mode bit: 0 general I/O, 1 lower write strobe.
// - Port A pin 3 field: 00 I/O, 01 chip select 7, 10 wait.
// - Pin 3 pull-up only in wait use, switched by bus controller.
// - Port A pin 2 field: 00 I/O, 01 chip select 6, 10 timer B.
// - Port A pin 1 field: 00 I/O, 01 chip select 5, 10 row strobe.
// - Port A pin 0 field: 00 I/O, 01 chip select 4, 10 timer A.
// - Port B direction: sixteen bits, 1 drives pin out, 0 input.
// - Direction bit used only in I/O, timer or serial clock function.
// - Port B direction clears on power-on reset only.
// - Two port B function registers: pins 15-8 and 7-0.
// - Port B function registers clear on power-on reset only.
// - Port B pin 15: 00 I/O, 01 interrupt 7, 11 pattern 15.
// - Port B pin 14: 00 I/O, 01 interrupt 6, 11 pattern 14.
// - Pin 13: 00 I/O, 01 interrupt 5, 10 serial clock, 11 pattern.
// - Bits 15, 13, 11 of port A low function read 1.
//
// Assumes the includer works on byte addresses of the APB slave.
`ifndef PORT_PIN_REGS_VH
`define PORT_PIN_REGS_VH

// Byte offsets, one aligned word per register
`define PA_LOW_FUNC_OFFSET 8'h00
`define PB_DIRECTION_OFFSET 8'h04
`define PB_HIGH_FUNC_OFFSET 8'h08
`define PB_LOW_FUNC_OFFSET 8'h0c

// Reset values
`define PA_LOW_FUNC_RESET 16'hff95
`define PB_DIRECTION_RESET 16'h0000
`define PB_HIGH_FUNC_RESET 16'h0000
`define PB_LOW_FUNC_RESET 16'h0000

// Reserved bits of port A low function, always one
`define PA_LOW_FUNC_RSV_MASK 16'haa00

// Field positions in port A low function
`define PA5_MODE_BIT 10
`define PA4_MODE_BIT 8
`define PA3_MODE_LSB 6
`define PA2_MODE_LSB 4
`define PA1_MODE_LSB 2
`define PA0_MODE_LSB 0

// Field positions in port B high function
`define PB15_MODE_LSB 14
`define PB14_MODE_LSB 12
`define PB13_MODE_LSB 10

// Two-bit mode codes
`define MODE_GPIO 2'h0
`define MODE_ALT1 2'h1
`define MODE_ALT2 2'h2
`define MODE_ALT3 2'h3

`endif

// >>> design/pin_mux_cell.v
// One multiplexed pin: picks output level and enable by the mode code.
// Assumes the caller presents all four options already resolved.
`timescale 1ns/10ps
`default_nettype none

module pin_mux_cell (
   input wire clk,
   input wire resetn,
   input wire [1:0] mode,
   input wire [3:0] outOpt,
   input wire [3:0] oeOpt,
   output reg pinOut,
   output reg pinOe
);

   // Registered so the pad sees no glitch when the mode changes
   always @(posedge clk) begin
      if (!resetn) begin
         pinOut <= 1'b0;
         pinOe <= 1'b0; // Pad released while reset holds
      end else begin
         pinOut <= outOpt[mode];
         pinOe <= oeOpt[mode];
      end
   end

endmodule // pin_mux_cell

`default_nettype wire

// >>> design/port_pin_function_select.v
// Pin function multiplexer for port A pins 5..0 and port B pins 15..13,
// with the port A low function, port B direction and both port B
// function registers behind an APB slave.
// Assumes one clock; pins arrive asynchronous and are synchronised
// here; peripherals and port data logic run on clk. resetn is the
// power-on reset; manual reset, standby and sleep never reach it.
// Port B pins 12..0 are muxed by the port logic, which reads the
// exported direction word and both exported function words.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_regs.vh"

module port_pin_function_select #(
   parameter ADDR_W = 8,
   parameter PA_PINS = 6,
   parameter PB_PINS = 3
) (
   input wire clk,
   input wire resetn,
   // APB slave
   input wire [ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Port A pins 5..0
   input wire [PA_PINS-1:0] paPinIn,
   output wire [PA_PINS-1:0] paPinOut,
   output wire [PA_PINS-1:0] paPinOe,
   output reg pa3PullupEn,
   // Port B pins 15..13, bit 0 is pin 13
   input wire [PB_PINS-1:0] pbPinIn,
   output wire [PB_PINS-1:0] pbPinOut,
   output wire [PB_PINS-1:0] pbPinOe,
   // Port data logic
   input wire [PA_PINS-1:0] paGpioOut,
   input wire [PA_PINS-1:0] paGpioDir,
   output reg [PA_PINS-1:0] paGpioIn,
   input wire [PB_PINS-1:0] pbGpioOut,
   output reg [PB_PINS-1:0] pbGpioIn,
   output reg [15:0] pbDirection,
   output reg [15:0] pbHighFunction,
   output reg [15:0] pbLowFunction,
   // Bus controller
   input wire upperWriteStrobe,
   input wire lowerWriteStrobe,
   input wire chipSelectSeven,
   input wire chipSelectSix,
   input wire chipSelectFive,
   input wire chipSelectFour,
   input wire rowAddrStrobe,
   input wire waitPullupSel,
   output reg busWaitIn,
   // Timer unit channel 0
   input wire timer0CapcompAOut,
   input wire timer0CapcompAOe,
   input wire timer0CapcompBOut,
   input wire timer0CapcompBOe,
   output reg timer0CapcompAIn,
   output reg timer0CapcompBIn,
   // Interrupt inputs 7..5, timing patterns 15..13, serial clock one
   output reg [PB_PINS-1:0] extInterrupt,
   input wire [PB_PINS-1:0] timingPatternOut,
   input wire serialClockOneOut,
   output reg serialClockOneIn
);

   localparam NPINS = PA_PINS + PB_PINS;

   // Register state
   // pbDirection and the function words are outputs and hold state too
   reg [15:0] paLowFunction_q;
   reg [15:0] paLowFunction_d;
   reg [15:0] pbDirection_d;
   reg [15:0] pbHighFunction_d;
   reg [15:0] pbLowFunction_d;

   // Bus handshake state
   reg pready_d;
   reg pslverr_d;
   reg [31:0] prdata_d;
   reg addrHit;
   reg [15:0] readWord;

   // Pin synchronisers
   reg [NPINS-1:0] padSync1_q;
   reg [NPINS-1:0] padSync2_q;

   // Mode fields, one two-bit code per pin
   wire [1:0] pa5Mode;
   wire [1:0] pa4Mode;
   wire [1:0] pa3Mode;
   wire [1:0] pa2Mode;
   wire [1:0] pa1Mode;
   wire [1:0] pa0Mode;
   wire [1:0] pb15Mode;
   wire [1:0] pb14Mode;
   wire [1:0] pb13Mode;
   wire [2*NPINS-1:0] modeVec;
   wire [4*NPINS-1:0] outVec;
   wire [4*NPINS-1:0] oeVec;
   wire [NPINS-1:0] pinOutAll;
   wire [NPINS-1:0] pinOeAll;
   wire accessDone;

   // Single-bit fields widen to codes 00 and 01
   assign pa5Mode = {1'b0, paLowFunction_q[`PA5_MODE_BIT]};
   assign pa4Mode = {1'b0, paLowFunction_q[`PA4_MODE_BIT]};
   assign pa3Mode = paLowFunction_q[`PA3_MODE_LSB +: 2];
   assign pa2Mode = paLowFunction_q[`PA2_MODE_LSB +: 2];
   assign pa1Mode = paLowFunction_q[`PA1_MODE_LSB +: 2];
   assign pa0Mode = paLowFunction_q[`PA0_MODE_LSB +: 2];
   assign pb15Mode = pbHighFunction[`PB15_MODE_LSB +: 2];
   assign pb14Mode = pbHighFunction[`PB14_MODE_LSB +: 2];
   assign pb13Mode = pbHighFunction[`PB13_MODE_LSB +: 2];

   // Pin order: 0..5 are port A pins 0..5, 6..8 are port B pins 13..15
   assign modeVec = {pb15Mode, pb14Mode, pb13Mode, pa5Mode, pa4Mode,
                     pa3Mode, pa2Mode, pa1Mode, pa0Mode};

   // Option tables, code 3 at the top bit of each nibble. Reserved codes repeat
   // the general I/O entry so a stray write never drives a strobe.
   // Wait and interrupt uses never drive, whatever the direction bit.
   // Port A pin 0: I/O, chip select 4, timer A, reserved
   assign outVec[3:0] = {paGpioOut[0], timer0CapcompAOut,
                         chipSelectFour, paGpioOut[0]};
   assign oeVec[3:0] = {paGpioDir[0], timer0CapcompAOe,
                        1'b1, paGpioDir[0]};
   // Port A pin 1: I/O, chip select 5, row strobe, reserved
   assign outVec[7:4] = {paGpioOut[1], rowAddrStrobe,
                         chipSelectFive, paGpioOut[1]};
   assign oeVec[7:4] = {paGpioDir[1], 1'b1, 1'b1, paGpioDir[1]};
   // Port A pin 2: I/O, chip select 6, timer B, reserved
   assign outVec[11:8] = {paGpioOut[2], timer0CapcompBOut,
                          chipSelectSix, paGpioOut[2]};
   assign oeVec[11:8] = {paGpioDir[2], timer0CapcompBOe,
                         1'b1, paGpioDir[2]};
   // Port A pin 3: I/O, chip select 7, wait input, reserved
   assign outVec[15:12] = {paGpioOut[3], 1'b0,
                           chipSelectSeven, paGpioOut[3]};
   assign oeVec[15:12] = {paGpioDir[3], 1'b0, 1'b1, paGpioDir[3]};
   // Port A pin 4: I/O or lower write strobe; upper codes unreachable
   assign outVec[19:16] = {paGpioOut[4], paGpioOut[4],
                           lowerWriteStrobe, paGpioOut[4]};
   assign oeVec[19:16] = {paGpioDir[4], paGpioDir[4],
                          1'b1, paGpioDir[4]};
   // Port A pin 5: I/O or upper write / lower byte strobe
   assign outVec[23:20] = {paGpioOut[5], paGpioOut[5],
                           upperWriteStrobe, paGpioOut[5]};
   assign oeVec[23:20] = {paGpioDir[5], paGpioDir[5],
                          1'b1, paGpioDir[5]};
   // Port B pin 13: I/O, interrupt 5, serial clock, pattern 13
   assign outVec[27:24] = {timingPatternOut[0], serialClockOneOut,
                           1'b0, pbGpioOut[0]};
   assign oeVec[27:24] = {1'b1, pbDirection[13],
                          1'b0, pbDirection[13]};
   // Port B pin 14: I/O, interrupt 6, reserved, pattern 14
   assign outVec[31:28] = {timingPatternOut[1], pbGpioOut[1],
                           1'b0, pbGpioOut[1]};
   assign oeVec[31:28] = {1'b1, pbDirection[14],
                          1'b0, pbDirection[14]};
   // Port B pin 15: I/O, interrupt 7, reserved, pattern 15
   assign outVec[35:32] = {timingPatternOut[2], pbGpioOut[2],
                           1'b0, pbGpioOut[2]};
   assign oeVec[35:32] = {1'b1, pbDirection[15],
                          1'b0, pbDirection[15]};

   // One registered cell per pin keeps every pad output on a flop
   // Each cell adds one cycle from a peripheral level to the pad
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi = gi + 1) begin : gPin
         pin_mux_cell uCell (
            .clk(clk),
            .resetn(resetn),
            .mode(modeVec[2*gi +: 2]),
            .outOpt(outVec[4*gi +: 4]),
            .oeOpt(oeVec[4*gi +: 4]),
            .pinOut(pinOutAll[gi]),
            .pinOe(pinOeAll[gi])
         );
      end
   endgenerate

   assign paPinOut = pinOutAll[PA_PINS-1:0];
   assign paPinOe = pinOeAll[PA_PINS-1:0];
   assign pbPinOut = pinOutAll[NPINS-1:PA_PINS];
   assign pbPinOe = pinOeAll[NPINS-1:PA_PINS];

   // Two-flop synchroniser; only the second stage feeds any logic
   // The first stage may settle late, so no other logic taps it
   always @(posedge clk) begin
      if (!resetn) begin
         padSync1_q <= {NPINS{1'b0}};
         padSync2_q <= {NPINS{1'b0}};
      end else begin
         padSync1_q <= {pbPinIn, paPinIn};
         padSync2_q <= padSync1_q;
      end
   end

   // Inputs to peripherals; a deselected pin shows the idle level so
   // a pin in another use cannot fake a wait or an interrupt
   always @(posedge clk) begin
      if (!resetn) begin
         paGpioIn <= {PA_PINS{1'b0}};
         pbGpioIn <= {PB_PINS{1'b0}};
         busWaitIn <= 1'b1;
         timer0CapcompAIn <= 1'b0;
         timer0CapcompBIn <= 1'b0;
         extInterrupt <= {PB_PINS{1'b1}};
         serialClockOneIn <= 1'b0;
         pa3PullupEn <= 1'b0;
      end else begin
         paGpioIn <= padSync2_q[PA_PINS-1:0];
         pbGpioIn <= padSync2_q[NPINS-1:PA_PINS];
         busWaitIn <= (pa3Mode == `MODE_ALT2) ?
                      padSync2_q[3] : 1'b1;
         timer0CapcompAIn <= (pa0Mode == `MODE_ALT2) &
                             padSync2_q[0];
         timer0CapcompBIn <= (pa2Mode == `MODE_ALT2) &
                             padSync2_q[2];
         extInterrupt[0] <= (pb13Mode == `MODE_ALT1) ?
                            padSync2_q[6] : 1'b1;
         extInterrupt[1] <= (pb14Mode == `MODE_ALT1) ?
                            padSync2_q[7] : 1'b1;
         extInterrupt[2] <= (pb15Mode == `MODE_ALT1) ?
                            padSync2_q[8] : 1'b1;
         serialClockOneIn <= (pb13Mode == `MODE_ALT2) &
                             padSync2_q[6];
         // Pull-up only in wait use, chosen by the bus controller
         pa3PullupEn <= (pa3Mode == `MODE_ALT2) & waitPullupSel;
      end
   end

   // APB: one wait state, so read data and the error come from flops
   assign accessDone = psel & penable & pready;

   // Address decode and read mux; upper half of the word reads zero
   // Unmapped offsets raise pslverr through addrHit
   always @* begin
      addrHit = 1'b1;
      readWord = 16'h0000;
      case (paddr)
         `PA_LOW_FUNC_OFFSET: begin
            readWord = paLowFunction_q | `PA_LOW_FUNC_RSV_MASK;
         end
         `PB_DIRECTION_OFFSET: begin
            readWord = pbDirection;
         end
         `PB_HIGH_FUNC_OFFSET: begin
            readWord = pbHighFunction;
         end
         `PB_LOW_FUNC_OFFSET: begin
            readWord = pbLowFunction;
         end
         default: begin
            addrHit = 1'b0;
         end
      endcase
   end

   // Handshake: pready rises in the second access cycle
   // A fixed wait state keeps the address decode off the ready path
   always @* begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata;
      if (psel && penable && !pready) begin
         pready_d = 1'b1;
         pslverr_d = ~addrHit;
         prdata_d = pwrite ? 32'h00000000 : {16'h0000, readWord};
      end
   end

   // Register writes land at the edge that completes the access
   // A refused address never reaches a register
   always @* begin
      paLowFunction_d = paLowFunction_q;
      pbDirection_d = pbDirection;
      pbHighFunction_d = pbHighFunction;
      pbLowFunction_d = pbLowFunction;
      if (accessDone && pwrite && !pslverr) begin
         case (paddr)
            `PA_LOW_FUNC_OFFSET: begin
               // Reserved bits stay one whatever software writes
               paLowFunction_d = pwdata[15:0] |
                                 `PA_LOW_FUNC_RSV_MASK;
            end
            `PB_DIRECTION_OFFSET: begin
               pbDirection_d = pwdata[15:0];
            end
            `PB_HIGH_FUNC_OFFSET: begin
               pbHighFunction_d = pwdata[15:0];
            end
            `PB_LOW_FUNC_OFFSET: begin
               pbLowFunction_d = pwdata[15:0];
            end
            default: begin
               pbLowFunction_d = pbLowFunction;
            end
         endcase
      end
   end

   // Only the power-on reset clears the registers; other resets and
   // low-power states have no path in here, so contents survive
   always @(posedge clk) begin
      if (!resetn) begin
         paLowFunction_q <= `PA_LOW_FUNC_RESET;
         pbDirection <= `PB_DIRECTION_RESET;
         pbHighFunction <= `PB_HIGH_FUNC_RESET;
         pbLowFunction <= `PB_LOW_FUNC_RESET;
      end else begin
         paLowFunction_q <= paLowFunction_d;
         pbDirection <= pbDirection_d;
         pbHighFunction <= pbHighFunction_d;
         pbLowFunction <= pbLowFunction_d;
      end
   end

   // Bus answer flops
   // prdata holds its value between accesses, and a write answer loads zero
   always @(posedge clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= pready_d;
         pslverr <= pslverr_d;
         prdata <= prdata_d;
      end
   end

endmodule // port_pin_function_select

`default_nettype wire

// >>> verif/port_pin_chk.sv
// Checker for the pin function select block: APB answer timing,
// reserved bits and the port B pin multiplexer.
// Assumes it is bound to the top module, with one clock and resetn.
`timescale 1ns/10ps
`default_nettype none

module port_pin_chk #(
   parameter ADDR_W = 8,
   parameter PB_PINS = 3
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PB_PINS-1:0] pbPinIn,
   input wire logic [PB_PINS-1:0] pbPinOut,
   input wire logic [PB_PINS-1:0] pbPinOe,
   input wire logic [PB_PINS-1:0] pbGpioOut,
   input wire logic [15:0] pbDirection,
   input wire logic [15:0] pbHighFunction,
   input wire logic [PB_PINS-1:0] extInterrupt,
   input wire logic [PB_PINS-1:0] timingPatternOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Only four aligned words answer without an error
   wire mapped = (paddr[ADDR_W-1:4] == 0) && (paddr[1:0] == 2'h0);

   // Setup, one wait state, then a single-cycle answer
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready ##1 !pready;
   endsequence
   // Pin 13 must stay in interrupt mode across the synchroniser
   sequence s_irq13_held;
      (pbHighFunction[11:10] == 2'h1) [*4];
   endsequence

   a_ready_wait: assert property (s_setup |=> s_answer)
      else $error("answer not after exactly one wait state");
   a_slverr_map: assert property (pready |-> pslverr == !mapped)
      else $error("error flag does not match address map");
   a_rsvd_ones: assert property (pready && !pwrite && paddr == 0
      |-> (prdata & 32'hffffaa00) == 32'h0000aa00)
      else $error("reserved port A bits not read as one");
   a_pattern_drive: assert property ($past(pbHighFunction[13:12])
      == 2'h3 |-> pbPinOe[1] && pbPinOut[1] == $past(timingPatternOut[1]))
      else $error("pattern output not driven on pin 14");
   a_irq_nodrive: assert property ($past(pbHighFunction[15:14])
      == 2'h1 |-> !pbPinOe[2])
      else $error("pin 15 driven in interrupt mode");
   a_sck_dir: assert property ($past(pbHighFunction[11:10]) == 2'h2
      |-> pbPinOe[0] == $past(pbDirection[13]))
      else $error("serial clock drive ignores direction");
   a_gpio_dir: assert property ($past(pbHighFunction[15:14]) == 2'h0
      |-> pbPinOe[2] == $past(pbDirection[15])
      && (!pbPinOe[2] || pbPinOut[2] == $past(pbGpioOut[2])))
      else $error("pin 15 general output wrong");
   a_irq_input: assert property (s_irq13_held
      |-> extInterrupt[0] == $past(pbPinIn[0], 3))
      else $error("interrupt five does not follow pin 13");
endmodule // port_pin_chk

`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the pin function select block.
// Assumes the design files and the checker; the bench is the APB master.
`timescale 1ns/10ps
`default_nettype none

module tb;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pa3PullupEn, busWaitIn, serialClockOneIn;
   logic timer0CapcompAIn, timer0CapcompBIn;
   logic [5:0] paPinIn = 6'h05, paGpioOut = 6'h2a, paGpioDir = 6'h15;
   logic [5:0] paPinOut, paPinOe, paGpioIn;
   logic [2:0] pbPinIn = 3'h1, pbGpioOut = 3'h3, timingPatternOut = 3'h6;
   logic [2:0] pbPinOut, pbPinOe, pbGpioIn, extInterrupt;
   logic [15:0] pbDirection, pbHighFunction, pbLowFunction;
   logic upperWriteStrobe = 1'h1, lowerWriteStrobe = 1'h0;
   logic chipSelectSeven = 1'h1, chipSelectSix = 1'h0;
   logic chipSelectFive = 1'h1, chipSelectFour = 1'h0;
   logic rowAddrStrobe = 1'h1, waitPullupSel = 1'h1;
   logic timer0CapcompAOut = 1'h1, timer0CapcompAOe = 1'h1;
   logic timer0CapcompBOut = 1'h0, timer0CapcompBOe = 1'h1;
   logic serialClockOneOut = 1'h1;
   int bad_count = 0;
   int n_compared = 0;

   typedef struct {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [15:0] x;
      logic e;
   } row_t;
   // Reset reads first, so a second reset can reuse rows 0..3
   row_t rows [16] = '{
      '{1'h0, 8'h00, 32'h0, 16'hff95, 1'h0},
      '{1'h0, 8'h04, 32'h0, 16'h0000, 1'h0},
      '{1'h0, 8'h08, 32'h0, 16'h0000, 1'h0},
      '{1'h0, 8'h0c, 32'h0, 16'h0000, 1'h0},
      '{1'h1, 8'h04, 32'hffffa5c3, 16'h0, 1'h0},
      '{1'h0, 8'h04, 32'h0, 16'ha5c3, 1'h0},
      '{1'h1, 8'h08, 32'h00005a5a, 16'h0, 1'h0},
      '{1'h0, 8'h08, 32'h0, 16'h5a5a, 1'h0},
      '{1'h1, 8'h0c, 32'h00001234, 16'h0, 1'h0},
      '{1'h0, 8'h0c, 32'h0, 16'h1234, 1'h0},
      '{1'h1, 8'h00, 32'h0000aa00, 16'h0, 1'h0},
      '{1'h0, 8'h00, 32'h0, 16'haa00, 1'h0},
      '{1'h1, 8'h00, 32'h0000ffaa, 16'h0, 1'h0},
      '{1'h0, 8'h00, 32'h0, 16'hffaa, 1'h0},
      '{1'h1, 8'h10, 32'h0000dead, 16'h0, 1'h1},
      '{1'h0, 8'h10, 32'h0, 16'h0000, 1'h1}
   };

   port_pin_function_select i_dut (.*);

   // 20 MHz clock
   always #25 clk = ~clk;

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t register read %h, want %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t pin state %h, want %h", $time, got, exp);
      end
   endtask

   // Called just after a rising edge; b2b keeps psel up for the next setup
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic b2b,
         output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("[ERR] %0t no ready from slave", $time);
      end
      rd = prdata;
      err = pslverr;
      if (!b2b) begin
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge clk);
      end
   endtask

   task automatic run_rows(input int lo, input int hi);
      logic [31:0] rd;
      logic err;
      for (int i = lo; i <= hi; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d, 1'h0, rd, err);
         chk_pin({7'h0, err}, {7'h0, rows[i].e});
         if (!rows[i].w)
            chk_reg(rd, {16'h0, rows[i].x});
      end
   endtask

   // Pins settle one cycle after the mode register; wait a few more
   task automatic pa_case(input logic [15:0] v, input logic [5:0] oe,
         input logic [5:0] om, input logic pu, input logic wt,
         input logic ta, input logic tbi);
      logic [31:0] rd;
      logic err;
      apb(1'h1, 8'h00, {16'h0, v}, 1'h0, rd, err);
      repeat (4) @(posedge clk);
      chk_pin({2'h0, paPinOe}, {2'h0, oe});
      chk_pin({2'h0, paPinOut & paPinOe}, {2'h0, om});
      chk_pin({4'h0, pa3PullupEn, busWaitIn, timer0CapcompAIn,
         timer0CapcompBIn}, {4'h0, pu, wt, ta, tbi});
      chk_pin({2'h0, paGpioIn}, {2'h0, paPinIn});
      $display("port A case %h done", v);
   endtask

   // Mode and direction written back to back
   task automatic pb_case(input logic [15:0] hi, input logic [15:0] dir,
         input logic [2:0] oe, input logic [2:0] om,
         input logic [2:0] irq, input logic sck);
      logic [31:0] rd;
      logic err;
      apb(1'h1, 8'h08, {16'h0, hi}, 1'h1, rd, err);
      apb(1'h1, 8'h04, {16'h0, dir}, 1'h0, rd, err);
      repeat (4) @(posedge clk);
      chk_pin({5'h0, pbPinOe}, {5'h0, oe});
      chk_pin({5'h0, pbPinOut & pbPinOe}, {5'h0, om});
      chk_pin({4'h0, extInterrupt, serialClockOneIn}, {4'h0, irq, sck});
      chk_pin({5'h0, pbGpioIn}, {5'h0, pbPinIn});
      $display("port B case %h/%h done", hi, dir);
   endtask

   // Whole run needs about 175 cycles
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      test_done;
   end

   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      run_rows(0, 15);
      $display("register table done");
      pa_case(16'hff95, 6'h37, 6'h22, 1'h1, 1'h0, 1'h0, 1'h0);
      pa_case(16'haa69, 6'h1f, 6'h0a, 1'h0, 1'h1, 1'h0, 1'h1);
      pa_case(16'haa2a, 6'h17, 6'h03, 1'h0, 1'h1, 1'h1, 1'h1);
      waitPullupSel <= 1'h0;
      pa_case(16'hff95, 6'h37, 6'h22, 1'h0, 1'h0, 1'h0, 1'h0);
      pb_case(16'hd800, 16'h2000, 3'h5, 3'h5, 3'h5, 1'h1);
      pb_case(16'h4000, 16'h2000, 3'h1, 3'h1, 3'h3, 1'h0);
      pb_case(16'h5400, 16'he000, 3'h0, 3'h0, 3'h1, 1'h0);
      pb_case(16'hfc00, 16'h0000, 3'h7, 3'h6, 3'h7, 1'h0);
      pb_case(16'h0800, 16'h0000, 3'h0, 3'h0, 3'h7, 1'h1);
      // Second power-on reset in mid-run must clear everything again
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      run_rows(0, 3);
      $display("second reset done");
      test_done;
   end
endmodule // tb

bind port_pin_function_select port_pin_chk #(
   .ADDR_W(ADDR_W),
   .PB_PINS(PB_PINS)
) i_chk (.*);

`default_nettype wire
